// ==== logic/lpm_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1: Deep sleep stops main oscillator; secondary-clocked time base and watchdog keep running.
// RULE2: Deep-sleep instruction clears the interrupt mask bit.
// RULE3: Deep sleep keeps all registers except mask, memory and I/O lines.
// RULE4: Deep sleep ends on IRQ, keyboard, slave SPI, secondary-clocked PULSE_WIDTH_COUNTER/TIME_BASE_INTERRUPT, reset.
// RULE5: Idle gates processor clock; timer clocks keep running.
// RULE6: Idle instruction clears the interrupt mask bit.
// RULE7: Idle keeps all registers except mask, memory and I/O lines.
// RULE8: Enabled time base interrupt ends idle.
// RULE9: External interrupt or reset also ends idle.
// RULE10: Enabled watchdog stays active in every mode.
// RULE11: Watchdog on main oscillator freezes during deep sleep.
// RULE12: Watchdog timeout issues full reset.
// RULE13: Software should disable watchdog for long low-power stays.
// RULE14: Software needing main-clock watchdog avoids deep sleep or uses secondary clock.
// RULE15: Single-chip mode keeps address and data bus internal.
// RULE16: Processor clock returns before CPU services the waking event.
module lpm_ctrl
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire lpm_pkg::lpm_bus_t bus,
   output logic [7:0] rdata,
   // CPU side
   input wire logic stop_exec,
   input wire logic wait_exec,
   output logic clear_imask,
   output logic cpu_clk_en,
   output logic wake_pulse,
   // Wake sources
   input wire lpm_pkg::lpm_wake_t wake,
   // Clock ticks and oscillator status
   input wire logic main_tick,
   input wire logic sec_tick,
   input wire logic main_osc_ready,
   input wire logic sec_osc_ready,
   output logic main_osc_en,
   output logic timer_clk_en,
   // Reset and bus pins
   output logic wd_reset,
   output logic ext_bus_oe,
   output logic irq_out
);
   import lpm_pkg::*;

   lpm_state_t state;
   lpm_state_t next_state;
   logic [7:0] tbc2;
   logic [7:0] ctrl;
   logic [EV_NUM-1:0] status;
   logic [EV_NUM-1:0] mask;
   logic [15:0] wd_load;
   logic [7:0] restart_cnt;
   logic [7:0] wd_rst_cnt;
   logic [EV_NUM-1:0] ev;
   logic stop_wake;
   logic idle_wake;
   logic wd_tick;
   logic wd_timeout;

   function automatic logic hit(input lpm_bus_t b, input logic [7:0] a);
      hit = b.wr && (b.addr == a);
   endfunction

   // Wake qualification
   always_comb
   begin
      stop_wake = wake.irq || wake.kbd || (wake.spi && wake.spi_slave)
         || ((wake.pulse_width_counter || wake.time_base_interrupt) && wake.tb_on_sec); // [RULE4]
      idle_wake = wake.irq || (wake.time_base_interrupt && tbc2[TBC2_TBIE]); // [RULE8] [RULE9]
   end

   // Power state sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         LPM_RUN:
         begin
            if (stop_exec)
               next_state = LPM_STOP;
            else if (wait_exec)
               next_state = LPM_IDLE;
         end
         LPM_IDLE:
            if (idle_wake)
               next_state = LPM_RUN;
         LPM_STOP:
            if (stop_wake)
               next_state = LPM_RESTART;
         LPM_RESTART:
            // Hold CPU until the oscillator is back and settled
            if (main_osc_ready && restart_cnt >= 8'(OSC_START_CYC))
               next_state = LPM_RUN; // [RULE16]
         default:
            next_state = LPM_RUN;
      endcase
   end

   // Reset and watchdog reset both return to run
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || wd_reset)
         state <= LPM_RUN;
      else
         state <= next_state;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn || state != LPM_RESTART)
         restart_cnt <= 8'h00;
      else if (main_osc_ready && restart_cnt < 8'hFF)
         restart_cnt <= restart_cnt + 8'h01;
   end

   // Clock gating outputs; registers simply hold while gated
   always_comb
   begin
      cpu_clk_en = (state == LPM_RUN); // [RULE5] [RULE3] [RULE7] [RULE16]
      main_osc_en = (state != LPM_STOP) && ctrl[CTRL_FAST_OSCILLATOR_ENABLE]; // [RULE1]
      timer_clk_en = (state != LPM_STOP) || ctrl[CTRL_WDSRC]; // [RULE1] [RULE5]
      clear_imask = (state == LPM_RUN) && (stop_exec || wait_exec); // [RULE2] [RULE6]
      wake_pulse = (state != LPM_RUN) && (next_state == LPM_RUN);
      ext_bus_oe = 1'b0; // [RULE15]
      irq_out = |(status & mask);
   end

   // Watchdog tick source; main ticks vanish in deep sleep
   always_comb
   begin
      if (ctrl[CTRL_WDSRC])
         wd_tick = sec_tick; // [RULE1]
      else
         wd_tick = main_tick && (state != LPM_STOP); // [RULE11]
   end

   lpm_watchdog u_wd (
      .sys_clk(sys_clk),
      .rstn(rstn && !wd_reset),
      .enable(tbc2[TBC2_WDEN]), // [RULE10]
      .tick(wd_tick),
      .kick(hit(bus, ADDR_TBC2) && bus.wdata[TBC2_WDCLR]),
      .load(wd_load),
      .timeout(wd_timeout)
   );

   // Stretch timeout into a full reset pulse
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         wd_rst_cnt <= 8'h00;
      else if (wd_timeout)
         wd_rst_cnt <= 8'(WD_RST_CYC); // [RULE12]
      else if (wd_rst_cnt != 8'h00)
         wd_rst_cnt <= wd_rst_cnt - 8'h01;
   end
   assign wd_reset = (wd_rst_cnt != 8'h00);

   // Software registers
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         tbc2 <= TBC2_RESET;
         ctrl <= CTRL_RESET;
         mask <= '0;
         wd_load <= WD_LOAD_RESET;
      end
      else
      begin
         if (hit(bus, ADDR_TBC2))
            tbc2 <= {1'b0, bus.wdata[TBC2_TBIE], 4'h0, bus.wdata[TBC2_WDEN], 1'b0};
         if (hit(bus, ADDR_CTRL))
            ctrl <= bus.wdata;
         if (hit(bus, ADDR_MASK))
            mask <= bus.wdata[EV_NUM-1:0];
         if (hit(bus, ADDR_WDLD))
            wd_load <= {bus.wdata, 8'h00};
      end
   end

   // Sticky events; set beats write-one-to-clear
   always_comb
   begin
      ev = '0;
      ev[EV_WAKE_STOP] = (state == LPM_RESTART) && (next_state == LPM_RUN);
      ev[EV_WAKE_IDLE] = (state == LPM_IDLE) && (next_state == LPM_RUN);
      ev[EV_WD_TIMEOUT] = wd_timeout;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         status <= '0;
      else if (hit(bus, ADDR_STAT))
         status <= (status & ~bus.wdata[EV_NUM-1:0]) | ev;
      else
         status <= status | ev;
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !bus.rd)
         rdata <= 8'h00;
      else
      begin
         case (bus.addr)
            ADDR_MISC:
               rdata <= {main_osc_ready, sec_osc_ready, 2'b00, ctrl[CTRL_SYS_HI],
                  ctrl[CTRL_SYS_LO], ctrl[CTRL_FAST_OSCILLATOR_ENABLE], ctrl[CTRL_OPTION_MAP_SELECT]};
            ADDR_TBC2:
               rdata <= tbc2;
            ADDR_CTRL:
               rdata <= ctrl;
            ADDR_STAT:
               rdata <= {5'h00, status};
            ADDR_MASK:
               rdata <= {5'h00, mask};
            ADDR_WDLD:
               rdata <= wd_load[15:8];
            default:
               rdata <= 8'h00;
         endcase
      end
   end
endmodule

// ==== logic/lpm_pkg.sv ====
package lpm_pkg;
   // Register map (byte offsets on the plain register port)
   localparam logic [7:0] ADDR_MISC = 8'h3E;
   localparam logic [7:0] ADDR_TBC2 = 8'h11;
   localparam logic [7:0] ADDR_CTRL = 8'h40;
   localparam logic [7:0] ADDR_STAT = 8'h41;
   localparam logic [7:0] ADDR_MASK = 8'h42;
   localparam logic [7:0] ADDR_WDLD = 8'h43;
   // Second time base control layout
   localparam int TBC2_TBIE = 6;
   localparam int TBC2_WDEN = 1;
   localparam int TBC2_WDCLR = 0;
   localparam logic [7:0] TBC2_RESET = 8'h00;
   // Control register layout
   localparam int CTRL_WDSRC = 0;
   localparam int CTRL_FAST_OSCILLATOR_ENABLE = 1;
   localparam int CTRL_SYS_LO = 2;
   localparam int CTRL_SYS_HI = 3;
   localparam int CTRL_OPTION_MAP_SELECT = 4;
   localparam logic [7:0] CTRL_RESET = 8'h02;
   // Status bits
   localparam int EV_WAKE_STOP = 0;
   localparam int EV_WAKE_IDLE = 1;
   localparam int EV_WD_TIMEOUT = 2;
   localparam int EV_NUM = 3;
   // Watchdog
   localparam logic [15:0] WD_LOAD_RESET = 16'hFFFF;
   localparam int WD_RST_NS = 50;
   localparam int CLK_NS = 5;
   localparam int WD_RST_CYC = (WD_RST_NS + CLK_NS - 1) / CLK_NS;
   // Oscillator restart wait (sys_clk cycles with main oscillator ready before CPU clock returns)
   localparam int OSC_START_CYC = 16;

   typedef enum logic [1:0] {LPM_RUN, LPM_IDLE, LPM_STOP, LPM_RESTART} lpm_state_t;

   typedef struct packed {
      logic irq;
      logic kbd;
      logic spi;
      logic spi_slave;
      logic pulse_width_counter;
      logic time_base_interrupt;
      logic tb_on_sec;
   } lpm_wake_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lpm_bus_t;
endpackage

// ==== logic/lpm_watchdog.sv ====
`timescale 1ns/1ps
module lpm_watchdog
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Control
   input wire logic enable,
   input wire logic tick,
   input wire logic kick,
   input wire logic [15:0] load,
   // Result
   output logic timeout
);
   import lpm_pkg::*;
   logic [15:0] count;

   // Counts only on ticks, so a halted source freezes it
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !enable || kick)
      begin
         count <= 16'h0000;
         timeout <= 1'b0;
      end
      else if (tick)
      begin
         if (count >= load)
         begin
            timeout <= 1'b1;
            count <= 16'h0000;
         end
         else
         begin
            timeout <= 1'b0;
            count <= count + 16'h0001;
         end
      end
      else
         timeout <= 1'b0;
   end
endmodule

// ==== tb/lpm_ctrl_sva.sv ====
`timescale 1ns/1ps
module lpm_ctrl_sva
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Observed ports
   input wire logic stop_exec,
   input wire logic wait_exec,
   input wire logic clear_imask,
   input wire logic cpu_clk_en,
   input wire logic wake_pulse,
   input wire lpm_pkg::lpm_wake_t wake,
   input wire logic main_osc_en,
   input wire logic timer_clk_en,
   input wire logic wd_reset,
   input wire logic ext_bus_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [4:0] wd_cnt;
   logic in_idle;
   logic in_stop;
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !wd_reset)
         wd_cnt <= 5'h00;
      else
         wd_cnt <= wd_cnt + 5'h01;
   end
   // Tracks which sleep was entered, since both look alike at the ports
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || cpu_clk_en)
      begin
         in_idle <= cpu_clk_en && wait_exec && !stop_exec;
         in_stop <= cpu_clk_en && stop_exec;
      end
   end
   imask_clear_a: assert property (clear_imask == (cpu_clk_en && (stop_exec || wait_exec)))
      else $error("mask clear pulse wrong");
   clk_gate_a: assert property (cpu_clk_en && (stop_exec || wait_exec) |=> !cpu_clk_en)
      else $error("cpu clock not gated");
   osc_halt_a: assert property (cpu_clk_en && stop_exec |=> !main_osc_en)
      else $error("main oscillator still on");
   tmr_run_a: assert property (in_idle && !cpu_clk_en |-> timer_clk_en)
      else $error("timer clock off while idle");
   wd_freeze_a: assert property ($past(!timer_clk_en, 2) |-> !$rose(wd_reset))
      else $error("watchdog expired with its clock stopped");
   bus_int_a: assert property (!ext_bus_oe)
      else $error("bus driven outside");
   wake_clk_a: assert property (wake_pulse |=> cpu_clk_en)
      else $error("cpu clock late after wake");
   idle_irq_a: assert property (in_idle && !cpu_clk_en && wake.irq |-> wake_pulse)
      else $error("irq did not end idle");
   stop_kbd_a: assert property (in_stop && $rose(wake.kbd) |-> ##[1:40] cpu_clk_en)
      else $error("keyboard did not end deep sleep");
   wd_len_a: assert property ($fell(wd_reset) && $past(rstn) |-> wd_cnt == 5'(WD_RST_CYC))
      else $error("watchdog reset length wrong");
   cover property (wake_pulse);
   cover property ($rose(wd_reset));
   cover property (cpu_clk_en && stop_exec);
   cover property (!cpu_clk_en && !main_osc_en && timer_clk_en);
endmodule
bind lpm_ctrl lpm_ctrl_sva u_lpm_ctrl_sva (.sys_clk, .rstn, .stop_exec, .wait_exec,
   .clear_imask, .cpu_clk_en, .wake_pulse, .wake, .main_osc_en, .timer_clk_en, .wd_reset,
   .ext_bus_oe);

// ==== tb/lpm_cpu_model.sv ====
`timescale 1ns/1ps
module lpm_cpu_model
(
   // Clock
   input wire logic sys_clk,
   // Core side
   output logic stop_exec,
   output logic wait_exec
);
   initial
   begin
      stop_exec = 1'b0;
      wait_exec = 1'b0;
   end
   // Naps run with the watchdog off; only the two watchdog checks break this
   task automatic exec_op(input logic deep);
      @(posedge sys_clk);
      stop_exec <= deep;
      wait_exec <= !deep;
      @(posedge sys_clk);
      stop_exec <= 1'b0;
      wait_exec <= 1'b0;
   endtask
endmodule

// ==== tb/lpm_ctrl_bench.sv ====
`timescale 1ns/1ps
module lpm_ctrl_bench;
   import lpm_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   lpm_bus_t bus = '0;
   lpm_wake_t wake = '0;
   logic stop_exec, wait_exec, clear_imask, cpu_clk_en, wake_pulse, main_osc_en;
   logic timer_clk_en, wd_reset, ext_bus_oe, irq_out;
   logic rd_d = 1'b0;
   logic [7:0] rdata, ld;
   logic [7:0] exp_q[$];
   // Bit 7 picks deep sleep, the rest is the wake source pattern
   logic [7:0] wake_tab[7] = '{8'hA0, 8'h98, 8'h85, 8'h83, 8'hC0, 8'h40, 8'h02};
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   integer seed = 32'h578E7E9F;
   always #2.5 sys_clk = ~sys_clk;
   // Oscillator model: ready and ticking whenever enabled
   lpm_ctrl u_lpm_ctrl (.sys_clk, .rstn, .bus, .rdata, .stop_exec, .wait_exec, .clear_imask,
      .cpu_clk_en, .wake_pulse, .wake, .main_tick(main_osc_en), .sec_tick(1'b1),
      .main_osc_ready(main_osc_en), .sec_osc_ready(1'b1), .main_osc_en, .timer_clk_en,
      .wd_reset, .ext_bus_oe, .irq_out);
   lpm_cpu_model u_lpm_cpu_model (.sys_clk, .stop_exec, .wait_exec);
   task automatic results();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want)
      begin
         errors++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // Write when w is set, else read expecting d
   task automatic bus_op(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge sys_clk);
      bus <= '{a, w ? d : 8'h00, w, !w};
      if (!w)
         exp_q.push_back(d);
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
   endtask
   task automatic nap(input logic [7:0] w);
      u_lpm_cpu_model.exec_op(w[7]);
      @(posedge sys_clk);
      wake <= w[6:0];
      n = 0;
      #1;
      while (!cpu_clk_en && n < 100)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check(cpu_clk_en, 1'b1);
      check(irq_out, w[7]);
      @(posedge sys_clk);
      wake <= '0;
      bus_op(ADDR_STAT, w[7] ? 8'h01 : 8'h02, 1'b0);
      bus_op(ADDR_STAT, 8'h03, 1'b1);
   endtask
   always @(posedge sys_clk)
   begin
      rd_d <= bus.rd;
      if (rd_d)
         check(rdata, exp_q.pop_front());
      cyc++;
      if (cyc == 6000)
      begin
         errors++;
         results();
      end
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      bus_op(ADDR_MISC, 8'hC2, 1'b0);
      bus_op(8'h3F, 8'h00, 1'b0);
      bus_op(ADDR_CTRL, CTRL_RESET, 1'b0);
      bus_op(ADDR_MASK, 8'h01, 1'b1);
      bus_op(ADDR_TBC2, 8'h40, 1'b1);
      foreach (wake_tab[i])
         nap(wake_tab[i]);
      bus_op(ADDR_MASK, 8'h01, 1'b0);
      bus_op(ADDR_TBC2, 8'h40, 1'b0);
      // Main-clocked watchdog outlasting a deep sleep must stay frozen
      bus_op(ADDR_WDLD, 8'h01, 1'b1);
      bus_op(ADDR_TBC2, 8'h02, 1'b1);
      u_lpm_cpu_model.exec_op(1'b1);
      repeat (300) @(posedge sys_clk);
      check(wd_reset, 1'b0);
      check(main_osc_en, 1'b0);
      wake <= 7'h40;
      n = 0;
      #1;
      while (!cpu_clk_en && n < 100)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check(cpu_clk_en, 1'b1);
      @(posedge sys_clk);
      wake <= '0;
      bus_op(ADDR_TBC2, 8'h00, 1'b1);
      bus_op(ADDR_STAT, 8'h07, 1'b1);
      // Secondary-clocked watchdog keeps counting and ends deep sleep
      bus_op(ADDR_CTRL, 8'h03, 1'b1);
      ld = 8'h01 | 8'($random(seed) & 3);
      bus_op(ADDR_WDLD, ld, 1'b1);
      bus_op(ADDR_WDLD, ld, 1'b0);
      bus_op(ADDR_TBC2, 8'h02, 1'b1);
      u_lpm_cpu_model.exec_op(1'b1);
      n = 0;
      while (!wd_reset && n < 1000)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check(wd_reset, 1'b1);
      check(cpu_clk_en, 1'b0);
      repeat (12) @(posedge sys_clk);
      check(cpu_clk_en, 1'b1);
      bus_op(ADDR_STAT, 8'h04, 1'b0);
      repeat (2) @(posedge sys_clk);
      results();
   end
endmodule
